/* lemb_host_model.sv */
// Host controller model: sinks the event message stream, logs each byte
// with its last flag, and answers key requests when the bench allows it.
// Assumes valid/ready on the block's single aclk.
`timescale 1ns/1ps
module lemb_host_model
  import lemb_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Message stream
  input  wire logic [7:0] msg_byte,
  input  wire logic       msg_valid,
  input  wire logic       msg_last,
  output logic            msg_ready,
  // Key answer to the block
  output logic            key_setting_command,
  // Behaviour set by the bench
  input  wire logic       slow,
  input  wire logic       answer_key
);
  logic [8:0] rx_q[$];
  logic [4:0] idx_q;
  logic [7:0] code_q;
  logic [3:0] delay_q;
  logic       tick_q;
  wire        take = msg_valid && msg_ready;
  wire        key_done = take && msg_last && code_q == CODE_KEYREQ;

  // Slow host takes a byte only every other cycle
  assign msg_ready = slow ? tick_q : 1'b1;

  // Byte log; the bench pops it, so a lost byte shows up at once
  always @(posedge aclk)
    if (aresetn && take)
      rx_q.push_back({msg_last, msg_byte});

  // Framing tracker, and a key answer well inside the deadline
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idx_q <= 5'h00;
      code_q <= 8'h00;
      delay_q <= 4'h0;
      tick_q <= 1'b0;
      key_setting_command <= 1'b0;
    end
    else
    begin
      tick_q <= ~tick_q;
      key_setting_command <= (delay_q == 4'h1);
      if (take)
        idx_q <= msg_last ? 5'h00 : idx_q + 5'h01;
      if (take && idx_q == 5'h01)
        code_q <= msg_byte;
      if (key_done && answer_key)
        delay_q <= 4'h6;
      else if (delay_q != 4'h0)
        delay_q <= delay_q - 4'h1;
    end
  end
endmodule

/* lemb_link_event_message_builder.sv */
// Event message builder: queues link events and streams their messages
// byte by byte to the host message interface, with AXI4-Lite registers.
// Assumes event pulses are synchronous to aclk and the stream sink obeys
// valid/ready.
// Operation
// - Timing report on connect or parameter update
// - Timing report: length 7, code 0x89
// - Connection interval sent high byte first
// - Interval field in 1.25 ms units
// - Latency low byte first, at most 0x03E8
// - Link timeout field in 10 ms units
// - Passkey display: length 7, code 0x8E
// - Pairing events only when configured and enabled
// - Key request: length 2, code 0x8F, kind 1
// - No key in 30 s: fail bond, drop link
// - Credit return: length 2, code 0x8A
// - Credits equal locations freed since last return
// - Pipe failure report, code 0x8D, on failure
// - Pipe, nonzero error code, up to 27 bytes
`timescale 1ns/1ps
module lemb_link_event_message_builder
  import lemb_pkg::*;
#(
  parameter int unsigned KEY_WAIT_CYCLES = KEY_TIMEOUT_CYCLES
)(
  // Clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]    s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [11:0]    s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  // Link events from the radio controller, and the host's key answer
  input  wire logic           conn_timing_evt,
  input  wire lemb_timing_t   conn_timing,
  input  wire logic           passkey_show_evt,
  input  wire logic [23:0]    passkey_bcd,
  input  wire logic           passkey_entry_evt,
  input  wire logic           key_setting_command,
  input  wire logic           credit_freed,
  input  wire logic           pipe_fail_evt,
  input  wire lemb_pipe_err_t pipe_fail,
  // Message byte stream to the host message interface
  output logic [7:0]          msg_byte,
  output logic                msg_valid,
  output logic                msg_last,
  input  wire logic           msg_ready,
  // Link supervision and interrupt
  output logic                bond_fail,
  output logic                link_terminate,
  output logic                irq
);

  // Saturating BCD digit to ASCII character
  function automatic logic [7:0] digit_ascii(input logic [3:0] d);
    logic [3:0] s;
    s = (d > DIGIT_MAX) ? DIGIT_MAX : d;
    return ASCII_ZERO + {4'h0, s};
  endfunction

  lemb_state_t          state_q, state_d;
  logic [MSG_BITS-1:0]  msg_q;
  logic [4:0]           left_q;
  lemb_timing_t         tim_q;
  lemb_pipe_err_t       pe_q;
  logic [23:0]          pk_q;
  logic                 tim_pend_q, pk_pend_q, kr_pend_q, pe_pend_q;
  logic [7:0]           credit_q;
  logic                 key_wait_q, kr_in_flight_q, fail_q;
  logic [31:0]          timer_q;
  logic [2:0]           ctrl_q;
  logic [ST_WIDTH-1:0]  status_q, mask_q;
  logic [11:0]          awaddr_q;
  logic [31:0]          wdata_q;
  logic                 aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic                 wstrb0_q;
  logic [1:0]           bresp_q, rresp_q;
  logic [31:0]          rdata_q;

  // Pairing events pass only after configuration with MITM and IO set
  wire pair_ok   = &ctrl_q;
  wire pk_set    = passkey_show_evt & pair_ok;
  wire kr_set    = passkey_entry_evt & pair_ok;

  // Message selection, fixed priority
  wire idle      = (state_q == ST_IDLE);
  wire any_pend  = pe_pend_q | kr_pend_q | pk_pend_q | tim_pend_q |
                   (credit_q != 8'h00);
  wire load      = idle & any_pend;
  wire sel_pe    = pe_pend_q;
  wire sel_kr    = !pe_pend_q & kr_pend_q;
  wire sel_pk    = !pe_pend_q & !kr_pend_q & pk_pend_q;
  wire sel_tim   = !pe_pend_q & !kr_pend_q & !pk_pend_q & tim_pend_q;
  wire sel_cr    = !pe_pend_q & !kr_pend_q & !pk_pend_q & !tim_pend_q;
  wire beat      = msg_valid & msg_ready;
  wire done      = beat & msg_last;

  // Message images, first byte in the low bits
  wire [63:0] img_tim = {tim_q.timeout[15:8], tim_q.timeout[7:0],
                         tim_q.latency[15:8], tim_q.latency[7:0],
                         tim_q.interval[7:0], tim_q.interval[15:8],
                         CODE_TIMING, LEN_TIMING};
  wire [63:0] img_pk  = {digit_ascii(pk_q[3:0]),
                         digit_ascii(pk_q[7:4]),
                         digit_ascii(pk_q[11:8]),
                         digit_ascii(pk_q[15:12]),
                         digit_ascii(pk_q[19:16]),
                         digit_ascii(pk_q[23:20]),
                         CODE_PASSKEY, LEN_PASSKEY};
  wire [23:0] img_kr  = {KIND_PASSKEY, CODE_KEYREQ, LEN_KEYREQ};
  wire [23:0] img_cr  = {credit_q, CODE_CREDIT, LEN_CREDIT};
  wire [7:0]  pe_len  = LEN_PIPE_BASE + {3'h0, pe_q.dlen};
  wire [MSG_BITS-1:0] img_pe = {pe_q.data, pe_q.code, pe_q.pipe,
                                CODE_PIPEERR, pe_len};

  wire [MSG_BITS-1:0] next_img =
      sel_pe  ? img_pe :
      sel_kr  ? MSG_BITS'(img_kr) :
      sel_pk  ? MSG_BITS'(img_pk) :
      sel_tim ? MSG_BITS'(img_tim) : MSG_BITS'(img_cr);
  wire [4:0] next_cnt =
      sel_pe  ? BYTES_PIPE + pe_q.dlen :
      sel_pk  ? BYTES_PASSKEY :
      sel_tim ? BYTES_TIMING : BYTES_SHORT;

  // Captured event fields, limited to their legal ranges
  wire [15:0] lat_lim  = (conn_timing.latency > LATENCY_MAX) ?
                         LATENCY_MAX : conn_timing.latency;
  wire [4:0]  dlen_lim = (pipe_fail.dlen > PIPE_DATA_MAX) ?
                         PIPE_DATA_MAX : pipe_fail.dlen;
  wire [7:0]  code_nz  = (pipe_fail.code == 8'h00) ?
                         PIPE_ERR_UNKN : pipe_fail.code;

  // Stream outputs: byte from the shift image, valid from the state
  assign msg_byte       = msg_q[7:0];
  assign msg_valid      = (state_q == ST_SEND);
  assign msg_last       = msg_valid & (left_q == 5'h01);
  assign bond_fail      = fail_q;
  assign link_terminate = fail_q;
  assign irq            = |(status_q & mask_q);

  // Sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (load) state_d = ST_SEND;
      ST_SEND: if (done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Shift register; one message at a time, no extra buffering
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      msg_q   <= '0;
      left_q  <= 5'h00;
    end
    else
    begin
      state_q <= state_d;
      if (load)
      begin
        msg_q  <= next_img;
        left_q <= next_cnt;
      end
      else if (beat)
      begin
        msg_q  <= {8'h00, msg_q[MSG_BITS-1:8]};
        left_q <= left_q - 5'h01;
      end
    end
  end

  // Pending events; a new event in the cycle of its load wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tim_pend_q <= 1'b0;
      pk_pend_q  <= 1'b0;
      kr_pend_q  <= 1'b0;
      pe_pend_q  <= 1'b0;
      tim_q      <= '0;
      pk_q       <= 24'h00_0000;
      pe_q       <= '0;
    end
    else
    begin
      tim_pend_q <= conn_timing_evt | (tim_pend_q & !(load & sel_tim));
      pk_pend_q  <= pk_set | (pk_pend_q & !(load & sel_pk));
      kr_pend_q  <= kr_set | (kr_pend_q & !(load & sel_kr));
      pe_pend_q  <= pipe_fail_evt | (pe_pend_q & !(load & sel_pe));
      if (conn_timing_evt)
        tim_q <= '{interval: conn_timing.interval,
                   latency:  lat_lim,
                   timeout:  conn_timing.timeout};
      if (pk_set)
        pk_q <= passkey_bcd;
      if (pipe_fail_evt)
        pe_q <= '{data: pipe_fail.data, dlen: dlen_lim,
                  code: code_nz, pipe: pipe_fail.pipe};
    end
  end

  // Credits freed since the last return; saturates rather than wraps
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      credit_q <= 8'h00;
    else if (load & sel_cr)
      credit_q <= {7'h00, credit_freed};
    else if (credit_freed & (credit_q != CREDIT_MAX))
      credit_q <= credit_q + 8'h01;
  end

  // Key entry deadline, counted from the end of the key request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      kr_in_flight_q <= 1'b0;
      key_wait_q     <= 1'b0;
      timer_q        <= 32'h0000_0000;
      fail_q         <= 1'b0;
    end
    else
    begin
      fail_q <= 1'b0;
      if (load)
        kr_in_flight_q <= sel_kr;
      if (done & kr_in_flight_q)
      begin
        key_wait_q <= 1'b1;
        timer_q    <= KEY_WAIT_CYCLES;
      end
      else if (key_wait_q & key_setting_command)
        key_wait_q <= 1'b0;
      else if (key_wait_q & (timer_q <= 32'h0000_0001))
      begin
        key_wait_q <= 1'b0;
        fail_q     <= 1'b1;
      end
      else if (key_wait_q)
        timer_q <= timer_q - 32'h0000_0001;
    end
  end

  // Register bus decode
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_go    = aw_have_q & w_have_q & !bvalid_q;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire [3:0] ev = {tim_pend_q & load & sel_tim, pe_pend_q & load & sel_pe,
                   fail_q, done};
  wire rd_stat  = ar_take & (s_axi_araddr == REG_STATUS);
  // Control and mask live in byte lane 0; a write without it is ignored
  wire wdata_strb0 = wstrb0_q;
  wire wr_ctrl  = wr_go & (awaddr_q == REG_CTRL) & wdata_strb0;
  wire wr_mask  = wr_go & (awaddr_q == REG_MASK) & wdata_strb0;
  wire wr_known = (awaddr_q == REG_CTRL) | (awaddr_q == REG_STATUS) |
                  (awaddr_q == REG_MASK) | (awaddr_q == REG_STATE);
  wire [31:0] rd_mux =
      (s_axi_araddr == REG_CTRL)   ? {29'h0, ctrl_q} :
      (s_axi_araddr == REG_STATUS) ? {28'h0, status_q} :
      (s_axi_araddr == REG_MASK)   ? {28'h0, mask_q} :
      {16'h0000, credit_q, 5'h00, key_wait_q, any_pend, msg_valid};
  wire rd_known = (s_axi_araddr == REG_CTRL) |
                  (s_axi_araddr == REG_STATUS) |
                  (s_axi_araddr == REG_MASK) | (s_axi_araddr == REG_STATE);

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Write channel: address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      wstrb0_q  <= 1'b0;
    end
    else
    begin
      if (aw_take)
        awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
      if (w_take)
        wstrb0_q <= s_axi_wstrb[0];
      if (w_take & s_axi_wstrb[0])
        wdata_q <= s_axi_wdata;
      else if (w_take)
        wdata_q <= {s_axi_wdata[31:8], wdata_q[7:0]};
      aw_have_q <= (aw_have_q | aw_take) & !wr_go;
      w_have_q  <= (w_have_q | w_take) & !wr_go;
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Control, mask and sticky status; a new event beats read-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q   <= 3'h0;
      mask_q   <= '0;
      status_q <= '0;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= wdata_q[2:0];
      if (wr_mask)
        mask_q <= wdata_q[ST_WIDTH-1:0];
      status_q <= ev | (status_q & {ST_WIDTH{!rd_stat}});
      if (ar_take)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_known ? rd_mux : 32'h0000_0000;
        rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // Checks
  a_timing_header: assert property (@(posedge aclk) disable iff (!aresetn)
    load & sel_tim |=> msg_q[15:0] == {CODE_TIMING, LEN_TIMING}
      && left_q == BYTES_TIMING)
    else $error("timing report header wrong");
  a_interval_msb_first: assert property (@(posedge aclk)
    disable iff (!aresetn)
    load & sel_tim |=> msg_q[23:16] == $past(tim_q.interval[15:8])
      && msg_q[31:24] == $past(tim_q.interval[7:0]))
    else $error("interval byte order wrong");
  a_latency_range: assert property (@(posedge aclk) disable iff (!aresetn)
    conn_timing_evt |=> tim_q.latency <= LATENCY_MAX)
    else $error("latency out of range");
  a_passkey_ascii: assert property (@(posedge aclk) disable iff (!aresetn)
    load & sel_pk |=> msg_q[15:0] == {CODE_PASSKEY, LEN_PASSKEY}
      && msg_q[23:16] >= ASCII_ZERO && msg_q[23:16] <= 8'h39)
    else $error("passkey message malformed");
  a_pairing_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(kr_pend_q) |-> $past(&ctrl_q))
    else $error("key request without pairing setup");
  a_keyreq_image: assert property (@(posedge aclk) disable iff (!aresetn)
    load & sel_kr |=> msg_q[23:0] == {KIND_PASSKEY, CODE_KEYREQ,
      LEN_KEYREQ} && left_q == BYTES_SHORT)
    else $error("key request message malformed");
  a_key_deadline: assert property (@(posedge aclk) disable iff (!aresetn)
    key_wait_q & !key_setting_command & timer_q == 32'h0000_0001
      |=> fail_q ##1 !fail_q)
    else $error("deadline expiry did not fail bond");
  a_credit_image: assert property (@(posedge aclk) disable iff (!aresetn)
    load & sel_cr |=> msg_q[15:0] == {CODE_CREDIT, LEN_CREDIT}
      && msg_q[23:16] == $past(credit_q))
    else $error("credit message malformed");
  a_pipe_length: assert property (@(posedge aclk) disable iff (!aresetn)
    load & sel_pe |=> msg_q[7:0] == 8'(left_q - 5'h01)
      && msg_q[15:8] == CODE_PIPEERR && msg_q[31:24] != 8'h00)
    else $error("pipe report length or code wrong");

  c_timing_sent: cover property (@(posedge aclk) disable iff (!aresetn)
    load & sel_tim ##[1:16] done);
  c_key_timeout: cover property (@(posedge aclk) disable iff (!aresetn)
    fail_q);
  c_pipe_sent: cover property (@(posedge aclk) disable iff (!aresetn)
    load & sel_pe ##[1:40] done);

endmodule

/* lemb_pkg.sv */
// Constants, field layouts and carrier types of the event message builder.
// Assumes a single 10 MHz clock and an AXI4-Lite register master.
package lemb_pkg;

  // Message headers: length byte counts event code plus content
  localparam logic [7:0] LEN_TIMING     = 8'h07;
  localparam logic [7:0] CODE_TIMING    = 8'h89;
  localparam logic [7:0] LEN_PASSKEY    = 8'h07;
  localparam logic [7:0] CODE_PASSKEY   = 8'h8E;
  localparam logic [7:0] LEN_KEYREQ     = 8'h02;
  localparam logic [7:0] CODE_KEYREQ    = 8'h8F;
  localparam logic [7:0] KIND_PASSKEY   = 8'h01;
  localparam logic [7:0] LEN_CREDIT     = 8'h02;
  localparam logic [7:0] CODE_CREDIT    = 8'h8A;
  localparam logic [7:0] CODE_PIPEERR   = 8'h8D;
  localparam logic [7:0] LEN_PIPE_BASE  = 8'h03;
  localparam logic [7:0] PIPE_ERR_UNKN  = 8'h80;

  // Field limits and encodings
  localparam logic [15:0] LATENCY_MAX   = 16'h03E8;
  localparam logic [4:0]  PIPE_DATA_MAX = 5'h1B;
  localparam logic [7:0]  ASCII_ZERO    = 8'h30;
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  localparam logic [7:0]  CREDIT_MAX    = 8'hFF;
  localparam logic [4:0]  BYTES_TIMING  = 5'h08;
  localparam logic [4:0]  BYTES_PASSKEY = 5'h08;
  localparam logic [4:0]  BYTES_SHORT   = 5'h03;
  localparam logic [4:0]  BYTES_PIPE    = 5'h04;
  localparam int          MSG_BITS      = 248;

  // Key entry deadline
  localparam int unsigned KEY_TIMEOUT_S      = 30;
  localparam int unsigned CLK_HZ             = 10_000_000;
  localparam int unsigned KEY_TIMEOUT_CYCLES = KEY_TIMEOUT_S * CLK_HZ;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_MASK   = 12'h008;
  localparam logic [11:0] REG_STATE  = 12'h00C;

  // Control and status bit positions
  localparam int CTRL_CFG_DONE  = 0;
  localparam int CTRL_MITM      = 1;
  localparam int CTRL_IOCAP     = 2;
  localparam int ST_SENT        = 0;
  localparam int ST_KEY_TIMEOUT = 1;
  localparam int ST_PIPE_ERR    = 2;
  localparam int ST_TIMING      = 3;
  localparam int ST_WIDTH       = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Carriers
  typedef struct packed {
    logic [15:0] interval;
    logic [15:0] latency;
    logic [15:0] timeout;
  } lemb_timing_t;

  typedef struct packed {
    logic [215:0] data;
    logic [4:0]   dlen;
    logic [7:0]   code;
    logic [7:0]   pipe;
  } lemb_pipe_err_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } lemb_state_t;

endpackage

/* testbench.sv */
// Self-checking bench for the event message builder: AXI4-Lite tasks,
// event pulses, and a host model that logs the message stream.
// Assumes a 10 MHz aclk and a shortened key deadline.
`timescale 1ns/1ps
module testbench;
  import lemb_pkg::*;
  localparam int KEY_W = 20;
  logic           aclk = 1'b0;
  logic           aresetn = 1'b0;
  logic [11:0]    s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]    s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]     s_axi_wstrb = 4'hF;
  logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic           s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
  logic           s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
  logic           s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]     s_axi_bresp, s_axi_rresp;
  logic           conn_timing_evt = 1'b0, passkey_show_evt = 1'b0;
  logic           passkey_entry_evt = 1'b0, credit_freed = 1'b0;
  logic           pipe_fail_evt = 1'b0, slow = 1'b0, answer_key = 1'b0;
  lemb_timing_t   conn_timing = '0;
  lemb_pipe_err_t pipe_fail = '0;
  logic [23:0]    passkey_bcd = '0;
  logic [7:0]     msg_byte;
  logic           msg_valid, msg_last, msg_ready, key_setting_command;
  logic           bond_fail, link_terminate, irq;
  logic [7:0]     exp_q[$];
  int             n_mismatch = 0;
  int             n_checks = 0;

  lemb_link_event_message_builder #(.KEY_WAIT_CYCLES(KEY_W))
    i_lemb_link_event_message_builder
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .conn_timing_evt, .conn_timing, .passkey_show_evt,
    .passkey_bcd, .passkey_entry_evt, .key_setting_command, .credit_freed,
    .pipe_fail_evt, .pipe_fail, .msg_byte, .msg_valid, .msg_last,
    .msg_ready, .bond_fail, .link_terminate, .irq
  );

  lemb_host_model i_lemb_host_model
  (
    .aclk, .aresetn, .msg_byte, .msg_valid, .msg_last, .msg_ready,
    .key_setting_command, .slow, .answer_key
  );

  // 100 ns period
  always #50 aclk = ~aclk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("mismatches %0d, checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task timeout;
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    results;
  endtask

  // Each channel released at its own handshake edge
  task axi_wr(input logic [11:0] a, input logic [31:0] d,
              input logic [1:0] resp);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) timeout;
    check(s_axi_bresp, resp);
    @(posedge aclk);
  endtask

  task axi_rd(input logic [11:0] a, input logic [31:0] d,
              input logic [1:0] resp);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) timeout;
    check(s_axi_rdata, d);
    check(s_axi_rresp, resp);
    @(posedge aclk);
  endtask

  // Compares the logged bytes with exp_q; last flag only on the final one
  task expect_msg;
    int i;
    for (i = 0; i < 400 && i_lemb_host_model.rx_q.size() < exp_q.size(); i++)
      @(posedge aclk);
    if (i_lemb_host_model.rx_q.size() < exp_q.size()) timeout;
    for (i = 0; i < exp_q.size(); i++)
      check(i_lemb_host_model.rx_q.pop_front(),
            {i == exp_q.size() - 1, exp_q[i]});
  endtask

  // Window allows for the edge on which the log and the bench meet
  task watch_bond(input logic fail);
    int i;
    int at;
    at = -1;
    for (i = 0; i < 60; i++)
    begin
      @(posedge aclk);
      if (bond_fail === 1'b1 && at < 0) at = i;
      check(link_terminate, bond_fail);
    end
    check(fail ? (at >= KEY_W - 2 && at <= KEY_W + 4) : (at < 0), 1'b1);
  endtask

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    axi_rd(REG_MASK, 32'h0000_0000, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h0000_0000, RESP_OKAY);
    axi_rd(12'h010, 32'h0000_0000, RESP_SLVERR);
    axi_wr(12'h010, 32'h0000_0007, RESP_SLVERR);
    // A mask write without byte lane 0 must leave the mask alone
    s_axi_wstrb <= 4'hE;
    axi_wr(REG_MASK, 32'h0000_000F, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(REG_MASK, 32'h0000_0000, RESP_OKAY);
    // Pairing pulses without the protection bit must be dropped
    axi_wr(REG_CTRL, 32'h0000_0005, RESP_OKAY);
    passkey_show_evt <= 1'b1;
    passkey_entry_evt <= 1'b1;
    @(posedge aclk);
    passkey_show_evt <= 1'b0;
    passkey_entry_evt <= 1'b0;
    repeat (20) @(posedge aclk);
    check(i_lemb_host_model.rx_q.size(), 32'h0000_0000);
    axi_wr(REG_CTRL, 32'h0000_0007, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h0000_0007, RESP_OKAY);
    axi_wr(REG_MASK, 32'h0000_0008, RESP_OKAY);
    // Timing report to a stalling host, latency above its limit
    slow <= 1'b1;
    conn_timing <= '{16'h1234, 16'h0500, 16'h0C80};
    conn_timing_evt <= 1'b1;
    @(posedge aclk);
    conn_timing_evt <= 1'b0;
    exp_q = '{8'h07, 8'h89, 8'h12, 8'h34, 8'hE8, 8'h03, 8'h80, 8'h0C};
    expect_msg;
    repeat (2) @(posedge aclk);
    check(irq, 1'b1);
    axi_rd(REG_STATUS, 32'h0000_0009, RESP_OKAY);
    check(irq, 1'b0);
    axi_rd(REG_STATUS, 32'h0000_0000, RESP_OKAY);
    // Credits freed while the passkey is still going out
    passkey_bcd <= 24'h09_0123;
    passkey_show_evt <= 1'b1;
    @(posedge aclk);
    passkey_show_evt <= 1'b0;
    @(posedge aclk);
    credit_freed <= 1'b1;
    repeat (3) @(posedge aclk);
    credit_freed <= 1'b0;
    // Passkey still going out, three credits waiting behind it
    axi_rd(REG_STATE, 32'h0000_0303, RESP_OKAY);
    exp_q = '{8'h07, 8'h8E, 8'h30, 8'h39, 8'h30, 8'h31, 8'h32, 8'h33};
    expect_msg;
    exp_q = '{8'h02, 8'h8A, 8'h03};
    expect_msg;
    // Key request left unanswered, then answered
    slow <= 1'b0;
    passkey_entry_evt <= 1'b1;
    @(posedge aclk);
    passkey_entry_evt <= 1'b0;
    exp_q = '{8'h02, 8'h8F, 8'h01};
    expect_msg;
    watch_bond(1'b1);
    check(irq, 1'b0);
    axi_rd(REG_STATUS, 32'h0000_0003, RESP_OKAY);
    answer_key <= 1'b1;
    passkey_entry_evt <= 1'b1;
    @(posedge aclk);
    passkey_entry_evt <= 1'b0;
    expect_msg;
    watch_bond(1'b0);
    axi_rd(REG_STATUS, 32'h0000_0001, RESP_OKAY);
    // Pipe failure with a zero code and two data bytes
    axi_wr(REG_MASK, 32'h0000_0004, RESP_OKAY);
    pipe_fail <= '{216'hBBAA, 5'h02, 8'h00, 8'h05};
    pipe_fail_evt <= 1'b1;
    @(posedge aclk);
    pipe_fail_evt <= 1'b0;
    exp_q = '{8'h05, 8'h8D, 8'h05, 8'h80, 8'hAA, 8'hBB};
    expect_msg;
    repeat (2) @(posedge aclk);
    check(irq, 1'b1);
    axi_rd(REG_STATUS, 32'h0000_0005, RESP_OKAY);
    results;
  end
endmodule
